// >>> logic/standby_pkg.sv
// Overview of operation
// RULE_01: unmasked maskable request ends idle mode
// RULE_02: idle wake latency 8-9 vectored, 2-3 next
// RULE_03: non-maskable request always ends idle, vectored
// RULE_04: unmasked test input ends idle, next instruction
// RULE_05: external reset ends idle, reset processing
// RULE_06: low priority serviced only with acknowledge and in-service
// RULE_07: stop entered only by instruction on main clock
// RULE_08: pending unmasked request at stop gives idle wait
// RULE_09: stop halts main oscillator, cpu; ports held
// RULE_10: stop halts watchdog, converter, async serial
// RULE_11: stop keeps 8-bit timers only on external input
// RULE_12: stop keeps watch, display only on subsystem clock
// RULE_13: unmasked maskable request ends stop after wait
// RULE_14: unmasked test input ends stop after wait
// RULE_15: external reset ends stop, wait, then reset
// RULE_16: stop ignores the non-maskable request
// RULE_17: wait counts selected main clock periods only
// RULE_18: wait counter blocks fetch until terminal count
package standby_pkg;
   localparam int IRQ_N = 8;
   localparam int AVS_AW = 4;
   localparam logic [3:0] ADDR_WAIT_SEL = 4'h0;
   localparam logic [3:0] ADDR_PERIPH_CFG = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [2:0] WAIT_SEL_RST = 3'h4;
   localparam logic [2:0] WAIT_SEL_MAX = 3'h4;
   localparam logic [4:0] PERIPH_CFG_RST = 5'h00;
   localparam int CFG_TMR8_EXT = 0;
   localparam int CFG_WATCH_SUB = 1;
   localparam int CFG_LCD_SUB = 2;
   localparam int CFG_SER_EXT = 3;
   localparam int CFG_SUB_PRESENT = 4;
   localparam int STAT_CAUSE_LSB = 4;
   localparam int STAB_BASE_LOG2_DEF = 13;
   localparam int STAB_CNT_W = 18;
   localparam logic [3:0] WAKE_SERVICE_CYCLES = 4'h8;
   localparam logic [3:0] WAKE_NEXT_CYCLES = 4'h2;

   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_HALT = 3'b001,
      ST_STOP = 3'b010,
      ST_STAB = 3'b011,
      ST_WAKE = 3'b100
   } state_e;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'b00,
      CAUSE_IRQ = 2'b01,
      CAUSE_TEST = 2'b10,
      CAUSE_RESET = 2'b11
   } cause_e;
endpackage

// >>> logic/stab_timer.sv
`timescale 1ns/100ps
`default_nettype none
module stab_timer #(
   parameter int BASE_LOG2 = 13
) (
   input wire logic core_clk_i,       // system clock
   input wire logic nrst_i,           // sync reset, active low
   input wire logic start_i,          // begin a new wait
   input wire logic osc_run_i,        // main oscillator is oscillating
   input wire logic [2:0] sel_i,      // wait select code
   output logic done_o                // one-cycle end of wait
);
   import standby_pkg::*;

   logic [STAB_CNT_W-1:0] cnt_reg;
   logic running_reg;
   logic [2:0] sel_eff;
   logic [STAB_CNT_W-1:0] terminal;
   logic at_end;

   // prohibited codes fall back to the longest wait
   assign sel_eff = (sel_i > WAIT_SEL_MAX) ? WAIT_SEL_MAX : sel_i;
   assign terminal = STAB_CNT_W'((64'(1) << (BASE_LOG2 + int'(sel_eff))) - 64'(1));
   // RULE_17: counts oscillating periods only
   assign at_end = running_reg && osc_run_i && (cnt_reg == terminal);

   // RULE_18: blocking counter
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cnt_reg <= '0;
         running_reg <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= at_end;
         if (start_i) begin
            cnt_reg <= '0;
            running_reg <= 1'b1;
         end else if (at_end) begin
            running_reg <= 1'b0;
         end else if (running_reg && osc_run_i) begin
            cnt_reg <= cnt_reg + STAB_CNT_W'(1);
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/standby_halt_stop_control.sv
`timescale 1ns/100ps
`default_nettype none
module standby_halt_stop_control #(
   parameter int STAB_BASE_LOG2 = standby_pkg::STAB_BASE_LOG2_DEF
) (
   input wire logic core_clk_i,                                        // 40 MHz clock
   input wire logic nrst_i,                                            // sync reset, low
   input wire logic [standby_pkg::AVS_AW-1:0] avs_address_i,           // byte address
   input wire logic avs_read_i,                                        // read request
   input wire logic avs_write_i,                                       // write request
   input wire logic [31:0] avs_writedata_i,                            // write data
   input wire logic [3:0] avs_byteenable_i,                            // byte lanes
   output logic [31:0] avs_readdata_o,                                 // read data
   output logic avs_waitrequest_o,                                     // stall
   input wire logic halt_exec_i,                                       // halt executed
   input wire logic stop_exec_i,                                       // stop executed
   input wire logic cpu_on_subclk_i,                                   // cpu on sub clock
   input wire logic [standby_pkg::IRQ_N-1:0] irq_req_i,                // request flags
   input wire logic [standby_pkg::IRQ_N-1:0] irq_mask_flag_i,          // mask flags
   input wire logic [standby_pkg::IRQ_N-1:0] irq_low_priority_flag_i,  // priority flags
   input wire logic global_irq_accept_enable_i,                        // acknowledge on
   input wire logic in_service_priority_flag_i,                        // in-service flag
   input wire logic nmi_req_i,                                         // non-maskable req
   input wire logic test_req_i,                                        // test input
   input wire logic test_mask_i,                                       // test mask
   input wire logic ext_reset_i,                                       // external reset
   input wire logic osc_started_i,                                     // main osc running
   output logic cpu_clk_en_o,                                          // cpu clock gate
   output logic main_osc_en_o,                                         // main osc enable
   output logic crystal_out_pullup_o,                                  // crystal out pull
   output logic port_latch_hold_o,                                     // freeze ports
   output logic wdt_run_o,                                             // watchdog clock
   output logic adc_run_o,                                             // converter clock
   output logic uart_run_o,                                            // async serial
   output logic serial_run_o,                                          // other serial
   output logic timer8_run_o,                                          // 8-bit timers
   output logic watch_run_o,                                           // watch timer
   output logic lcd_run_o,                                             // display driver
   output logic vector_service_o,                                      // take vector
   output logic resume_next_o,                                         // next instruction
   output logic reset_process_o                                        // reset processing
);
   import standby_pkg::*;

   // ----------------------------------------------------------
   // wake decoding
   // ----------------------------------------------------------
   function automatic logic irq_wake(input logic [IRQ_N-1:0] req,
                                     input logic [IRQ_N-1:0] mask);
      irq_wake = |(req & ~mask);
   endfunction

   function automatic logic irq_service(input logic [IRQ_N-1:0] req,
                                        input logic [IRQ_N-1:0] mask,
                                        input logic [IRQ_N-1:0] low,
                                        input logic ie,
                                        input logic in_service_priority_flag);
      logic [IRQ_N-1:0] open_req;
      open_req = req & ~mask;
      irq_service = ie && ((|(open_req & ~low)) || ((|(open_req & low)) && in_service_priority_flag));
   endfunction

   state_e state_reg;
   state_e state_next;
   cause_e cause_reg;
   cause_e cause_next;
   logic [3:0] wake_cnt_reg;
   logic [3:0] wake_cnt_next;
   logic wake_svc_reg;
   logic wake_svc_next;
   logic [2:0] wait_sel_reg;
   logic [4:0] periph_cfg_reg;
   logic stab_start;
   logic stab_done;

   wire logic irq_open = irq_wake(irq_req_i, irq_mask_flag_i);
   wire logic irq_svc = irq_service(irq_req_i, irq_mask_flag_i, irq_low_priority_flag_i,
                                    global_irq_accept_enable_i, in_service_priority_flag_i);
   wire logic test_open = test_req_i && !test_mask_i;
   // RULE_07: main clock only
   wire logic stop_ok = stop_exec_i && !cpu_on_subclk_i;
   wire logic wake_end = (state_reg == ST_WAKE) && (wake_cnt_reg == 4'h0);

   logic svc_pulse;
   logic next_pulse;
   logic rst_pulse;

   // ----------------------------------------------------------
   // mode sequencer
   // ----------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cause_next = cause_reg;
      wake_cnt_next = wake_cnt_reg;
      wake_svc_next = wake_svc_reg;
      stab_start = 1'b0;
      svc_pulse = 1'b0;
      next_pulse = 1'b0;
      rst_pulse = 1'b0;
      unique case (state_reg)
         ST_RUN: begin
            if (halt_exec_i) begin
               state_next = ST_HALT;
            end else if (stop_ok) begin
               // RULE_08: pending request, idle wait instead
               if (irq_open) begin
                  state_next = ST_STAB;
                  cause_next = CAUSE_IRQ;
                  stab_start = 1'b1;
               end else begin
                  state_next = ST_STOP;
               end
            end
         end
         ST_HALT: begin
            if (ext_reset_i) begin
               // RULE_05: reset leaves idle at once
               state_next = ST_RUN;
               cause_next = CAUSE_RESET;
               rst_pulse = 1'b1;
            end else if (nmi_req_i) begin
               // RULE_03: vectored regardless of enable
               state_next = ST_WAKE;
               cause_next = CAUSE_IRQ;
               wake_svc_next = 1'b1;
               wake_cnt_next = WAKE_SERVICE_CYCLES - 4'h1;
            end else if (irq_open) begin
               // RULE_01: masked requests keep idle
               // RULE_06: priority qualifies service
               state_next = ST_WAKE;
               cause_next = CAUSE_IRQ;
               wake_svc_next = irq_svc;
               // RULE_02: latency per resume kind
               wake_cnt_next = (irq_svc ? WAKE_SERVICE_CYCLES : WAKE_NEXT_CYCLES) - 4'h1;
            end else if (test_open) begin
               // RULE_04: test input resumes in line
               state_next = ST_WAKE;
               cause_next = CAUSE_TEST;
               wake_svc_next = 1'b0;
               wake_cnt_next = WAKE_NEXT_CYCLES - 4'h1;
            end
         end
         ST_STOP: begin
            // RULE_16: non-maskable request not a source
            if (ext_reset_i) begin
               // RULE_15: reset waits out stabilization
               state_next = ST_STAB;
               cause_next = CAUSE_RESET;
               stab_start = 1'b1;
            end else if (irq_open) begin
               // RULE_13: maskable release
               state_next = ST_STAB;
               cause_next = CAUSE_IRQ;
               stab_start = 1'b1;
            end else if (test_open) begin
               // RULE_14: test release
               state_next = ST_STAB;
               cause_next = CAUSE_TEST;
               stab_start = 1'b1;
            end
         end
         ST_STAB: begin
            // RULE_18: fetch blocked until count ends
            if (stab_done) begin
               state_next = ST_RUN;
               unique case (cause_reg)
                  CAUSE_RESET: rst_pulse = 1'b1;
                  CAUSE_IRQ: begin
                     svc_pulse = irq_svc;
                     next_pulse = !irq_svc;
                  end
                  default: next_pulse = 1'b1;
               endcase
            end
         end
         ST_WAKE: begin
            if (wake_end) begin
               state_next = ST_RUN;
               svc_pulse = wake_svc_reg;
               next_pulse = !wake_svc_reg;
            end else begin
               wake_cnt_next = wake_cnt_reg - 4'h1;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         state_reg <= ST_RUN;
         cause_reg <= CAUSE_NONE;
         wake_cnt_reg <= 4'h0;
         wake_svc_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cause_reg <= cause_next;
         wake_cnt_reg <= wake_cnt_next;
         wake_svc_reg <= wake_svc_next;
      end
   end

   stab_timer #(
      .BASE_LOG2(STAB_BASE_LOG2)
   ) u_stab (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .start_i(stab_start),
      .osc_run_i(osc_started_i),
      .sel_i(wait_sel_reg),
      .done_o(stab_done)
   );

   // ----------------------------------------------------------
   // clock and peripheral gating
   // ----------------------------------------------------------
   wire logic stop_next = (state_next == ST_STOP);
   wire logic cpu_on_next = (state_next == ST_RUN);
   wire logic sub_ok = periph_cfg_reg[CFG_SUB_PRESENT];

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cpu_clk_en_o <= 1'b1;
         main_osc_en_o <= 1'b1;
         crystal_out_pullup_o <= 1'b0;
         port_latch_hold_o <= 1'b0;
         vector_service_o <= 1'b0;
         resume_next_o <= 1'b0;
         reset_process_o <= 1'b0;
      end else begin
         cpu_clk_en_o <= cpu_on_next;
         // RULE_09: oscillator off, ports frozen
         main_osc_en_o <= !stop_next;
         crystal_out_pullup_o <= stop_next;
         port_latch_hold_o <= (state_next == ST_HALT) || stop_next;
         vector_service_o <= svc_pulse;
         resume_next_o <= next_pulse;
         reset_process_o <= rst_pulse;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wdt_run_o <= 1'b1;
         adc_run_o <= 1'b1;
         uart_run_o <= 1'b1;
         serial_run_o <= 1'b1;
         timer8_run_o <= 1'b1;
         watch_run_o <= 1'b1;
         lcd_run_o <= 1'b1;
      end else begin
         // RULE_10: clocked-from-core units stop
         wdt_run_o <= !stop_next;
         adc_run_o <= !stop_next;
         uart_run_o <= !stop_next;
         serial_run_o <= !stop_next || periph_cfg_reg[CFG_SER_EXT];
         // RULE_11: external count input only
         timer8_run_o <= !stop_next || periph_cfg_reg[CFG_TMR8_EXT];
         // RULE_12: subsystem clock needed
         watch_run_o <= !stop_next || (sub_ok && periph_cfg_reg[CFG_WATCH_SUB]);
         lcd_run_o <= !stop_next || (sub_ok && periph_cfg_reg[CFG_LCD_SUB]);
      end
   end

   // ----------------------------------------------------------
   // register slave
   // ----------------------------------------------------------
   // one wait cycle per access keeps readdata a clean flop
   wire logic avs_req = avs_read_i || avs_write_i;
   wire logic avs_take = avs_req && !avs_waitrequest_o;
   wire logic wr_lane0 = avs_write_i && avs_take && avs_byteenable_i[0];
   wire logic hit_sel = (avs_address_i == ADDR_WAIT_SEL);
   wire logic hit_cfg = (avs_address_i == ADDR_PERIPH_CFG);
   wire logic hit_stat = (avs_address_i == ADDR_STATUS);
   wire logic [31:0] rd_mux =
      hit_sel ? {29'h0, wait_sel_reg} :
      hit_cfg ? {27'h0, periph_cfg_reg} :
      hit_stat ? {26'h0, cause_reg, 1'b0, state_reg} : 32'h0;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
      end else begin
         avs_waitrequest_o <= !(avs_req && avs_waitrequest_o);
         if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rd_mux;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wait_sel_reg <= WAIT_SEL_RST;
         periph_cfg_reg <= PERIPH_CFG_RST;
      end else begin
         // RULE_17: programmable wait length
         if (wr_lane0 && hit_sel) begin
            wait_sel_reg <= avs_writedata_i[2:0];
         end
         if (wr_lane0 && hit_cfg) begin
            periph_cfg_reg <= avs_writedata_i[4:0];
         end
      end
   end

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   AST_HALT_MASK_HOLD: assert property ( // RULE_01
      (state_reg == ST_HALT) && !irq_open && !nmi_req_i && !test_open && !ext_reset_i
      |=> (state_reg == ST_HALT))
      else $error("idle mode left without a source");

   AST_HALT_SVC_LATENCY: assert property ( // RULE_02
      (state_reg == ST_HALT) && !ext_reset_i && !nmi_req_i && irq_open && irq_svc
      |-> ##9 vector_service_o)
      else $error("vectored resume latency wrong");

   AST_HALT_LOW_PRIO_NEXT: assert property ( // RULE_06
      (state_reg == ST_HALT) && !ext_reset_i && !nmi_req_i && irq_open &&
      !(|(irq_req_i & ~irq_mask_flag_i & ~irq_low_priority_flag_i)) &&
      !(global_irq_accept_enable_i && in_service_priority_flag_i)
      |-> ##3 resume_next_o)
      else $error("low priority wake not resumed in line");

   AST_HALT_NMI: assert property ( // RULE_03
      (state_reg == ST_HALT) && !ext_reset_i && nmi_req_i |-> ##9 vector_service_o)
      else $error("nmi did not give vectored service");

   AST_HALT_TEST: assert property ( // RULE_04
      (state_reg == ST_HALT) && !ext_reset_i && !nmi_req_i && !irq_open && test_open
      |-> ##1 !vector_service_o [*2] ##1 resume_next_o)
      else $error("test wake did not resume in line");

   AST_HALT_RESET: assert property ( // RULE_05
      (state_reg == ST_HALT) && ext_reset_i |=> reset_process_o && (state_reg == ST_RUN))
      else $error("reset in idle not processed");

   AST_STOP_ENTRY: assert property ( // RULE_07
      (state_reg == ST_STOP) && ($past(state_reg) == ST_RUN)
      |-> $past(stop_exec_i) && !$past(cpu_on_subclk_i) && !$past(halt_exec_i))
      else $error("stop entered without stop on main clock");

   AST_STOP_PENDING: assert property ( // RULE_08
      (state_reg == ST_RUN) && !halt_exec_i && stop_ok && irq_open
      |=> (state_reg == ST_STAB) && main_osc_en_o)
      else $error("pending request did not give idle wait");

   AST_STOP_GATES: assert property ( // RULE_09
      (state_reg == ST_STOP) |-> !main_osc_en_o && !cpu_clk_en_o && port_latch_hold_o &&
      !wdt_run_o && !adc_run_o && !uart_run_o)
      else $error("stop mode gating wrong");

   AST_STOP_TIMER8: assert property ( // RULE_11
      (state_reg == ST_STOP) && $stable(periph_cfg_reg)
      |-> (timer8_run_o == periph_cfg_reg[CFG_TMR8_EXT]))
      else $error("8-bit timer gating wrong in stop");

   AST_STOP_NMI_IGNORED: assert property ( // RULE_16
      (state_reg == ST_STOP) && nmi_req_i && !irq_open && !test_open && !ext_reset_i
      |=> (state_reg == ST_STOP))
      else $error("nmi released stop mode");

   AST_STAB_BLOCKS: assert property ( // RULE_18
      (state_reg == ST_STAB) && !stab_done |=> !cpu_clk_en_o && !vector_service_o &&
      !resume_next_o && !reset_process_o)
      else $error("fetch resumed before wait ended");

   COV_HALT_IRQ: cover property (
      (state_reg == ST_HALT) ##1 (state_reg == ST_WAKE) ##[1:10] vector_service_o);
   COV_STOP_TEST: cover property (
      (state_reg == ST_STOP) ##1 (state_reg == ST_STAB) && (cause_reg == CAUSE_TEST));
   COV_STOP_RESET: cover property (
      (state_reg == ST_STAB) && (cause_reg == CAUSE_RESET) && stab_done);
endmodule
`default_nettype wire

// >>> verification/core_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// processor core and main oscillator stand-in
// ----------------------------------------
module core_osc_model #(
   parameter int OSC_DLY = 5
) (
   input wire logic core_clk_i,     // system clock
   input wire logic go_halt_i,      // bench asks for a halt
   input wire logic go_stop_i,      // bench asks for a stop
   input wire logic main_osc_en_i,  // oscillator enable from block
   output logic halt_exec_o,        // halt instruction executed
   output logic stop_exec_o,        // stop instruction executed
   output logic osc_started_o       // oscillation running
);
   int unsigned ramp = OSC_DLY;
   // single driver per strobe; unknown only before the first edge, inside reset
   always @(posedge core_clk_i) begin
      halt_exec_o <= go_halt_i;
      stop_exec_o <= go_stop_i;
   end
   // start-up gap
   // a real crystal needs a while before it swings; the block must not count it
   always @(posedge core_clk_i) begin
      if (!main_osc_en_i) begin
         ramp <= 0;
      end else if (ramp < OSC_DLY) begin
         ramp <= ramp + 1;
      end
   end
   assign osc_started_o = main_osc_en_i && (ramp == OSC_DLY);
endmodule
`default_nettype wire

// >>> verification/tb_standby_halt_stop_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_standby_halt_stop_control;
   import standby_pkg::*;
   localparam int BASE = 2;
   localparam int OSC_DLY = 5;
   logic clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, wait_req;
   logic [3:0] addr = 4'h0, be = 4'hF;
   logic [31:0] wdata = 32'h0, rdata;
   logic go_halt = 1'b0, go_stop = 1'b0, halt_x, stop_x, subclk = 1'b0;
   logic [7:0] irq = 8'h00, mk = 8'hFF, low = 8'h00;
   logic ie = 1'b0, in_service_priority_flag = 1'b0, nmi = 1'b0, treq = 1'b0, tmask = 1'b1, xrst = 1'b0;
   logic osc_en, osc_ok, pull, hold, cpu_en, svc, nxt, rproc;
   logic wdt, adc, uart, ser, t8, wch, lcd;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   always #12.5 clk = ~clk;
   standby_halt_stop_control #(.STAB_BASE_LOG2(BASE)) u_dut (.core_clk_i(clk), .nrst_i(nrst),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
      .halt_exec_i(halt_x), .stop_exec_i(stop_x), .cpu_on_subclk_i(subclk), .irq_req_i(irq),
      .irq_mask_flag_i(mk), .irq_low_priority_flag_i(low), .global_irq_accept_enable_i(ie),
      .in_service_priority_flag_i(in_service_priority_flag), .nmi_req_i(nmi), .test_req_i(treq),
      .test_mask_i(tmask), .ext_reset_i(xrst), .osc_started_i(osc_ok), .cpu_clk_en_o(cpu_en),
      .main_osc_en_o(osc_en), .crystal_out_pullup_o(pull), .port_latch_hold_o(hold),
      .wdt_run_o(wdt), .adc_run_o(adc), .uart_run_o(uart), .serial_run_o(ser),
      .timer8_run_o(t8), .watch_run_o(wch), .lcd_run_o(lcd), .vector_service_o(svc),
      .resume_next_o(nxt), .reset_process_o(rproc));
   core_osc_model #(.OSC_DLY(OSC_DLY)) u_core (.core_clk_i(clk), .go_halt_i(go_halt),
      .go_stop_i(go_stop), .main_osc_en_i(osc_en), .halt_exec_o(halt_x),
      .stop_exec_o(stop_x), .osc_started_o(osc_ok));
   // ----------------------------------------
   // bench tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk); while (wait_req !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic do_reset();
      nrst <= 1'b0;
      {irq, low, ie, in_service_priority_flag, nmi, treq, xrst, subclk} <= '0;
      mk <= 8'hFF;
      tmask <= 1'b1;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
   endtask
   // mode 0 halt, 1 stop, 2 stop with request pending; src 0 irq 1 nmi 2 test 3 reset
   // ex 0 stays asleep, 1 vectored, 2 next instruction, 3 reset processing
   task automatic run(input int mode, src, input logic m, l, e, s, input logic [4:0] cfg,
                      input logic [2:0] sel, input int ex);
      logic [31:0] q;
      int n, lo;
      do_reset();
      bus(1'b1, ADDR_WAIT_SEL, {29'h0, sel}, q);
      bus(1'b1, ADDR_PERIPH_CFG, {27'h0, cfg}, q);
      ie <= e;
      in_service_priority_flag <= s;
      low <= {7'h0, l};
      mk <= {7'h7F, m};
      irq <= (mode == 2) ? 8'h01 : 8'h00;
      go_halt <= (mode == 0);
      go_stop <= (mode != 0);
      @(posedge clk);
      go_halt <= 1'b0;
      go_stop <= 1'b0;
      repeat (3) @(posedge clk);
      if (mode == 0) chk({osc_en, pull, hold, cpu_en, wdt, adc, uart, ser, t8, wch, lcd},
         11'b10101111111, "idle gating");
      if (mode == 1) chk({osc_en, pull, hold, cpu_en, wdt, adc, uart, ser, t8, wch, lcd},
         {7'b0110000, cfg[3], cfg[0], cfg[4] & cfg[1], cfg[4] & cfg[2]}, "stop gating");
      if (mode == 2) chk(osc_en, 1, "osc kept on");
      case (src)
         0: irq <= 8'h01;
         1: nmi <= 1'b1;
         2: begin
            tmask <= m;
            treq <= 1'b1;
         end
         default: xrst <= 1'b1;
      endcase
      n = 0;
      while (n < 300 && {svc, nxt, rproc} === 3'b000) begin
         @(posedge clk);
         n++;
      end
      chk({svc, nxt, rproc}, ex == 1 ? 3'b100 : ex == 2 ? 3'b010 : ex == 3 ? 3'b001 : 3'b000,
         "wake kind");
      lo = (1 << (BASE + sel)) + ((mode == 1) ? OSC_DLY : -4);
      if (mode == 0 && ex != 0) chk(n, ex == 1 ? 10 : ex == 2 ? 4 : 2, "idle latency");
      if (mode != 0 && ex != 0) chk(n >= lo && n <= lo + 12, 1, "stop wait");
      if (ex == 0) begin
         bus(1'b0, ADDR_STATUS, 32'h0, q);
         chk(q, (mode == 0) ? 32'h1 : 32'h2, "mode held");
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] q;
      do_reset();
      bus(1'b0, ADDR_WAIT_SEL, 32'h0, q);
      chk(q, 32'h4, "wait select reset");
      bus(1'b0, 4'hC, 32'h0, q);
      chk(q, 32'h0, "unmapped read");
      bus(1'b1, ADDR_STATUS, 32'h3, q);
      bus(1'b0, ADDR_STATUS, 32'h0, q);
      chk(q, 32'h0, "status after write");
      subclk <= 1'b1;
      go_stop <= 1'b1;
      @(posedge clk);
      go_stop <= 1'b0;
      repeat (3) @(posedge clk);
      chk({cpu_en, osc_en}, 2'b11, "stop on sub clock");
      run(0, 0, 0, 0, 0, 0, 0, 4, 2);
      run(0, 0, 0, 0, 1, 0, 0, 4, 1);
      run(0, 0, 0, 1, 0, 1, 0, 4, 2);
      run(0, 0, 0, 1, 1, 0, 0, 4, 2);
      run(0, 0, 0, 1, 1, 1, 0, 4, 1);
      run(0, 0, 1, 0, 1, 0, 0, 4, 0);
      run(0, 1, 0, 0, 0, 0, 0, 4, 1);
      run(0, 2, 0, 0, 1, 0, 0, 4, 2);
      run(0, 2, 1, 0, 1, 0, 0, 4, 0);
      run(0, 3, 0, 0, 0, 0, 0, 4, 3);
      run(1, 0, 0, 0, 1, 0, 5'h00, 4, 1);
      run(1, 0, 0, 0, 0, 0, 5'h1F, 0, 2);
      run(1, 0, 0, 1, 1, 0, 5'h0A, 1, 2);
      run(1, 0, 1, 0, 1, 0, 5'h15, 0, 0);
      run(1, 1, 0, 0, 1, 0, 0, 0, 0);
      run(1, 2, 0, 0, 1, 0, 0, 2, 2);
      run(1, 2, 1, 0, 1, 0, 0, 0, 0);
      run(1, 3, 0, 0, 0, 0, 0, 1, 3);
      run(2, 0, 0, 0, 1, 0, 0, 3, 1);
      give_verdict();
   end
endmodule
`default_nettype wire
